// >>> scif_cfg.svh
// Offsets, field positions, reset values and timing counts of the smartcard control block
`ifndef SCIF_CFG_SVH
`define SCIF_CFG_SVH
`define SCIF_OFS_CTRL 8'h00
`define SCIF_OFS_STAT 8'h04
`define SCIF_OFS_CONT 8'h08
`define SCIF_OFS_WT0 8'h0c
`define SCIF_OFS_WT1 8'h10
`define SCIF_OFS_WT2 8'h14
`define SCIF_OFS_IEN 8'h18
`define SCIF_OFS_IPEND 8'h1c
`define SCIF_OFS_TXB 8'h20
`define SCIF_OFS_RXB 8'h24
`define SCIF_OFS_MISC 8'h28
`define SCIF_CTRL_RST 8'h00
`define SCIF_CONT_RST 7'h00
`define SCIF_WT0_RST 8'h80
`define SCIF_WT1_RST 8'h25
`define SCIF_WT2_RST 8'h00
`define SCIF_B_SRST 7
`define SCIF_B_POL 6
`define SCIF_F_VSEL 5:4
`define SCIF_B_UART 3
`define SCIF_B_WAIT_COUNT_ENABLE 2
`define SCIF_B_AUTO_REPEAT_ENABLE 1
`define SCIF_B_BIT_ORDER_CONVENTION 0
`define SCIF_B_CLKSEL 7
`define SCIF_B_AUXB 5
`define SCIF_B_AUXA 4
`define SCIF_B_MIO 3
`define SCIF_B_MCLK 2
`define SCIF_B_CRST 1
`define SCIF_B_PWR 0
`define SCIF_B_SENT 2
`define SCIF_B_PARITY_ERROR_FLAG 0
`define SCIF_B_INSM 0
`define SCIF_SYS_CLK_NS 5
`define SCIF_CARD_CLK_NS 250
`define SCIF_CARD_HALF_CYC ((`SCIF_CARD_CLK_NS / 2) / `SCIF_SYS_CLK_NS)
`define SCIF_ETU_CARD_CLKS 372
`define SCIF_REPEAT_MAX 3'd4
`endif

// >>> scif_pkg.sv
// Types shared by the smartcard control block
package scif_pkg;
  typedef enum logic [1:0] {SCIF_IDLE, SCIF_TX, SCIF_RX} scif_state_t;
  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } scif_apb_req_t;
  typedef struct packed {
    logic det;
    logic overload;
    logic supply_ok;
  } scif_card_in_t;
  typedef struct packed {
    logic clk;
    logic rst;
    logic aux_a;
    logic aux_b;
    logic vcc_on;
    logic [1:0] vsel;
  } scif_card_out_t;
endpackage

// >>> scif_ctrl.sv
// Smartcard interface control: registers, waiting timer, character engine, detection, pins
//
// Notes on behaviour
// R1: UART mode with wait enable reloads the waiting counter at each start bit.
// R2: UART mode, enable clear: writing the high load byte loads the counter.
// R3: Software loads block then character waiting time around the last sent character.
// R4: Manual mode: high load byte write loads; counting starts once enable is set.
// R5: Two interrupt outputs: insertion/removal and one combined interface interrupt.
// R6: Reading the pending register clears the combined interrupt.
// R7: Events arriving during a pending register read are kept, not lost.
// R8: Polarity bit: 0 switch open without card, 1 switch closed without card.
// R9: Present flag follows every detect level change, no debouncing.
// R10: Card power can be on only while a card is present.
// R11: Removal clears present flag, raises enabled interrupt, clears power at once.
// R12: Power bit clear deactivates clock, I/O and both auxiliary contacts.
// R13: Soft reset bit holds the character engine in reset while set.
// R14: Voltage field selects 0V, 1.8V, 3V or 5V supply.
// R15: Mode 0: I/O pin mirrors manual bit; mode 1: engine drives it.
// R16: Software releases the manual I/O bit high before entering UART mode.
// R17: With repetition, up to 4 resends or retries; parity flag at fifth error.
// R18: Without repetition, no error signalling or resend; flag at first receive error, transmit errors ignored.
// R19: Finally refused character sets parity flag, leaves sent flag clear.
// R20: Direct sends b0 first, high is one; inverse sends b7 first, inverted.
// R21: Overflow flag reads one while the waiting counter sits at its limit.
// R22: Sent flag is set by hardware and held until software clears it.
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "scif_cfg.svh"
module scif_ctrl #(
  parameter int unsigned ETU_CYCLES = `SCIF_ETU_CARD_CLKS * 2 * `SCIF_CARD_HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire scif_pkg::scif_apb_req_t apb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire scif_pkg::scif_card_in_t card_in,
  input wire logic io_in,
  output logic io_out,
  output logic io_oe,
  output var scif_pkg::scif_card_out_t card_out,
  output logic card_irq,
  output logic insert_irq
);
  import scif_pkg::*;
  localparam int EW = $clog2(ETU_CYCLES);
  localparam int HW = $clog2(`SCIF_CARD_HALF_CYC);
  localparam logic [EW-1:0] ETU_LAST = EW'(ETU_CYCLES - 1);
  localparam logic [EW-1:0] ETU_MID = EW'(ETU_CYCLES / 2);
  localparam logic [HW-1:0] HALF_LAST = HW'(`SCIF_CARD_HALF_CYC - 1);

  if (ETU_CYCLES < 24) begin : g_chk
    $error("ETU_CYCLES must be at least 24");
  end

  logic det_q1, det_q2, ovl_q1, ovl_q2, vok_q1, vok_q2, io_q1, io_q2;
  logic io_prev, ovl_d, vok_d;
  logic setup, wr_en, rd_en, hit;
  logic wr_ctrl, wr_stat, wr_cont, wr_wt2, wr_ien, wr_txb, rd_ipr, rd_rxb;
  logic [7:0] rd_val, ctrl_r, ien_r, ipr_r, txbuf_r, rxbuf_r, sr_r;
  logic [7:1] ccr_r;
  logic [23:0] wt_ld_r, wt_cnt_r;
  logic misc_r, present_r, present_nxt, power_r, ins_irq_r;
  logic sent_r, rxf_r, parity_error_flag_r, txfull_r, wait_overflow_flag;
  logic srst, uart, auto_repeat_enable, bit_order_convention, wait_count_enable;
  scif_state_t st_r;
  logic [3:0] idx_r, bsel;
  logic [2:0] tries_r;
  logic err_r, tick, mid, tx_start, rx_start, sbit, tx_lvl, rx_v, drive_low;
  logic end_tx, end_rx, retry, tx_fail, txc_ev, rxc_ev, par_ev, wt_ev;
  logic [7:0] ev_m;
  logic [EW-1:0] etu_r;
  logic [HW-1:0] div_r;
  logic clk4_r;

  assign srst = ctrl_r[`SCIF_B_SRST];
  assign uart = ctrl_r[`SCIF_B_UART];
  assign auto_repeat_enable = ctrl_r[`SCIF_B_AUTO_REPEAT_ENABLE];
  assign bit_order_convention = ctrl_r[`SCIF_B_BIT_ORDER_CONVENTION];
  assign wait_count_enable = ctrl_r[`SCIF_B_WAIT_COUNT_ENABLE];

  // Pins from outside the clock domain: two flops before use
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {det_q2, det_q1, ovl_q2, ovl_q1, vok_q2, vok_q1} <= 6'h00;
      {io_q2, io_q1, io_prev, ovl_d, vok_d} <= 5'h1c;
    end
    else if (ce)
    begin
      {det_q2, det_q1} <= {det_q1, card_in.det};
      {ovl_q2, ovl_q1} <= {ovl_q1, card_in.overload};
      {vok_q2, vok_q1} <= {vok_q1, card_in.supply_ok};
      {io_q2, io_q1} <= {io_q1, io_in};
      io_prev <= io_q2;
      ovl_d <= ovl_q2;
      vok_d <= vok_q2;
    end
  end

  // APB slave: zero wait states, error on unmapped offsets
  assign setup = apb.psel & ~apb.penable;
  assign wr_en = apb.psel & apb.penable & apb.pwrite;
  assign rd_en = apb.psel & apb.penable & ~apb.pwrite;
  assign wr_ctrl = wr_en & (apb.paddr == `SCIF_OFS_CTRL);
  assign wr_stat = wr_en & (apb.paddr == `SCIF_OFS_STAT);
  assign wr_cont = wr_en & (apb.paddr == `SCIF_OFS_CONT);
  assign wr_wt2 = wr_en & (apb.paddr == `SCIF_OFS_WT2);
  assign wr_ien = wr_en & (apb.paddr == `SCIF_OFS_IEN);
  assign wr_txb = wr_en & (apb.paddr == `SCIF_OFS_TXB);
  assign rd_ipr = rd_en & (apb.paddr == `SCIF_OFS_IPEND);
  assign rd_rxb = rd_en & (apb.paddr == `SCIF_OFS_RXB);
  assign pready = 1'b1;
  assign pslverr = apb.psel & apb.penable & ~hit;

  always_comb
  begin
    hit = 1'b1;
    rd_val = 8'h00;
    case (apb.paddr)
      `SCIF_OFS_CTRL: rd_val = ctrl_r;
      `SCIF_OFS_STAT: rd_val = {~txfull_r, present_r, ovl_q2, vok_q2, wait_overflow_flag, sent_r, rxf_r, parity_error_flag_r};
      `SCIF_OFS_CONT: rd_val = {ccr_r[7], 1'b0, ccr_r[5:4], io_q2, ccr_r[2:1], power_r};
      `SCIF_OFS_WT0: rd_val = wt_ld_r[7:0];
      `SCIF_OFS_WT1: rd_val = wt_ld_r[15:8];
      `SCIF_OFS_WT2: rd_val = wt_ld_r[23:16];
      `SCIF_OFS_IEN: rd_val = ien_r;
      `SCIF_OFS_IPEND: rd_val = ipr_r;
      `SCIF_OFS_TXB: rd_val = txbuf_r;
      `SCIF_OFS_RXB: rd_val = rxbuf_r;
      `SCIF_OFS_MISC: rd_val = {7'h00, misc_r};
      default: hit = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle so it is stable in the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (ce && setup && !apb.pwrite)
      prdata <= {24'h00_0000, rd_val};
  end

  // Software configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= `SCIF_CTRL_RST;
      ccr_r <= `SCIF_CONT_RST;
      ien_r <= 8'h00;
      misc_r <= 1'b0;
      wt_ld_r <= {`SCIF_WT2_RST, `SCIF_WT1_RST, `SCIF_WT0_RST};
    end
    else if (ce)
    begin
      if (wr_ctrl)
        ctrl_r <= apb.pwdata[7:0];
      if (wr_cont)
        ccr_r <= {apb.pwdata[7], 1'b0, apb.pwdata[5:1]};
      if (wr_ien)
        ien_r <= apb.pwdata[7:0] & 8'hbf;
      if (wr_en && apb.paddr == `SCIF_OFS_MISC)
        misc_r <= apb.pwdata[`SCIF_B_INSM];
      if (wr_en && apb.paddr == `SCIF_OFS_WT0)
        wt_ld_r[7:0] <= apb.pwdata[7:0];
      if (wr_en && apb.paddr == `SCIF_OFS_WT1)
        wt_ld_r[15:8] <= apb.pwdata[7:0];
      if (wr_wt2)
        wt_ld_r[23:16] <= apb.pwdata[7:0];
    end
  end

  // Presence and card power
  assign present_nxt = det_q2 ^ ctrl_r[`SCIF_B_POL]; // [R8] [R9]
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      present_r <= 1'b0;
      power_r <= 1'b0;
      ins_irq_r <= 1'b0;
    end
    else if (ce)
    begin
      present_r <= present_nxt; // [R9]
      // Power bit is refused without a card and dropped on removal
      power_r <= (wr_cont ? apb.pwdata[`SCIF_B_PWR] : power_r) & present_nxt; // [R10] [R11]
      ins_irq_r <= (present_nxt != present_r) & misc_r; // [R5] [R11]
    end
  end
  assign insert_irq = ins_irq_r;

  // Elementary time unit prescaler, restarted at each start bit
  assign tick = (etu_r == '0);
  assign mid = (etu_r == ETU_MID);
  assign tx_start = uart & power_r & ~srst & (st_r == SCIF_IDLE) & txfull_r;
  assign rx_start = uart & power_r & ~srst & (st_r == SCIF_IDLE) & ~txfull_r & io_prev & ~io_q2;
  // A repeated character sends a fresh start bit, so it reloads the timer too
  assign sbit = tx_start | rx_start | (end_tx & retry);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      etu_r <= ETU_LAST;
    else if (ce)
      etu_r <= (sbit || tick) ? ETU_LAST : etu_r - 1'b1;
  end

  // Character engine; transmission wins over a start bit seen in the same cycle
  assign bsel = bit_order_convention ? 4'd8 - idx_r : idx_r - 4'd1;
  assign rx_v = io_q2 ^ bit_order_convention;
  always_comb
  begin
    if (idx_r == 4'd0)
      tx_lvl = 1'b0;
    else if (idx_r <= 4'd8)
      tx_lvl = sr_r[bsel[2:0]] ^ bit_order_convention; // [R20]
    else if (idx_r == 4'd9)
      tx_lvl = (^sr_r) ^ bit_order_convention; // [R20]
    else
      tx_lvl = 1'b1;
  end
  assign retry = err_r & auto_repeat_enable & (tries_r < `SCIF_REPEAT_MAX); // [R17]
  assign end_tx = (st_r == SCIF_TX) & tick & (idx_r == 4'd11);
  assign end_rx = (st_r == SCIF_RX) & tick & (idx_r == 4'd10);
  assign tx_fail = end_tx & err_r & ~retry; // [R19]
  assign txc_ev = end_tx & ~err_r;
  assign rxc_ev = end_rx & ~retry;
  assign par_ev = tx_fail | (end_rx & err_r & ~retry); // [R17] [R18]
  // Error signal only when repetition is on and retries remain
  assign drive_low = ((st_r == SCIF_TX) & ~tx_lvl) | ((st_r == SCIF_RX) & (idx_r == 4'd10) & retry);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= SCIF_IDLE;
      idx_r <= 4'd0;
      sr_r <= 8'h00;
      err_r <= 1'b0;
      tries_r <= 3'd0;
    end
    else if (ce)
    begin
      if (srst)
      begin
        st_r <= SCIF_IDLE; // [R13]
        idx_r <= 4'd0;
        err_r <= 1'b0;
        tries_r <= 3'd0;
      end
      else
      begin
        unique case (st_r)
          SCIF_IDLE:
          begin
            idx_r <= 4'd0;
            err_r <= 1'b0;
            if (tx_start)
            begin
              st_r <= SCIF_TX;
              sr_r <= txbuf_r;
            end
            else if (rx_start)
              st_r <= SCIF_RX;
          end
          SCIF_TX:
          begin
            // Card error signal sampled mid guard bit; ignored without repetition
            if (mid && idx_r == 4'd10 && !io_q2 && auto_repeat_enable)
              err_r <= 1'b1; // [R17] [R18]
            if (tick)
            begin
              idx_r <= idx_r + 4'd1;
              if (end_tx)
              begin
                idx_r <= 4'd0;
                err_r <= 1'b0;
                tries_r <= retry ? tries_r + 3'd1 : 3'd0; // [R17]
                if (!retry)
                  st_r <= SCIF_IDLE;
              end
            end
          end
          SCIF_RX:
          begin
            if (mid && idx_r >= 4'd1 && idx_r <= 4'd8)
              sr_r <= bit_order_convention ? {sr_r[6:0], rx_v} : {rx_v, sr_r[7:1]}; // [R20]
            if (mid && idx_r == 4'd9)
              err_r <= (^sr_r) ^ rx_v;
            if (tick)
            begin
              idx_r <= idx_r + 4'd1;
              if (end_rx)
              begin
                st_r <= SCIF_IDLE;
                tries_r <= retry ? tries_r + 3'd1 : 3'd0; // [R17]
              end
            end
          end
        endcase
      end
    end
  end

  // Buffers and sticky status; a hardware set wins over a software clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      txbuf_r <= 8'h00;
      txfull_r <= 1'b0;
      rxbuf_r <= 8'h00;
      rxf_r <= 1'b0;
      sent_r <= 1'b0;
      parity_error_flag_r <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_txb)
        txbuf_r <= apb.pwdata[7:0];
      txfull_r <= wr_txb | (txfull_r & ~tx_start & ~srst);
      if (rxc_ev)
        rxbuf_r <= sr_r;
      rxf_r <= rxc_ev | (rxf_r & ~rd_rxb & ~srst);
      sent_r <= txc_ev | (sent_r & ~(wr_stat & ~apb.pwdata[`SCIF_B_SENT])); // [R22]
      parity_error_flag_r <= par_ev | (parity_error_flag_r & ~(wr_stat & ~apb.pwdata[`SCIF_B_PARITY_ERROR_FLAG])); // [R19]
    end
  end

  // Waiting time counter: counts down per etu and parks at zero
  assign wait_overflow_flag = (wt_cnt_r == 24'h00_0000); // [R21]
  assign wt_ev = wait_count_enable & tick & (wt_cnt_r == 24'h00_0001);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wt_cnt_r <= {`SCIF_WT2_RST, `SCIF_WT1_RST, `SCIF_WT0_RST};
    else if (ce)
    begin
      if (sbit && uart && wait_count_enable)
        wt_cnt_r <= wt_ld_r; // [R1]
      else if (wr_wt2 && !wait_count_enable)
        wt_cnt_r <= {apb.pwdata[7:0], wt_ld_r[15:0]}; // [R2] [R4]
      else if (wait_count_enable && tick && !wait_overflow_flag)
        wt_cnt_r <= wt_cnt_r - 24'h00_0001; // [R4]
    end
  end

  // Pending events: a read clears only the bits it returned
  assign ev_m = ien_r & {tx_start, 1'b0, ovl_q2 & ~ovl_d, vok_d & ~vok_q2,
                         wt_ev, txc_ev, rxc_ev, par_ev}; // [R19]
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ipr_r <= 8'h00;
    else if (ce)
      ipr_r <= (ipr_r & ~(rd_ipr ? prdata[7:0] : 8'h00)) | ev_m; // [R6] [R7]
  end
  assign card_irq = |ipr_r; // [R5]

  // Card pins; everything low with power off, clock stops at a known level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_r <= '0;
      clk4_r <= 1'b0;
      card_out <= '0;
      io_oe <= 1'b1;
    end
    else if (ce)
    begin
      div_r <= (div_r == HALF_LAST) ? '0 : div_r + 1'b1;
      if (div_r == HALF_LAST)
        clk4_r <= ~clk4_r;
      card_out.clk <= power_r & (ccr_r[`SCIF_B_CLKSEL] ? clk4_r : ccr_r[`SCIF_B_MCLK]); // [R12]
      card_out.rst <= power_r & ccr_r[`SCIF_B_CRST];
      card_out.aux_a <= power_r & ccr_r[`SCIF_B_AUXA]; // [R12]
      card_out.aux_b <= power_r & ccr_r[`SCIF_B_AUXB]; // [R12]
      card_out.vcc_on <= power_r; // [R11]
      card_out.vsel <= power_r ? ctrl_r[`SCIF_F_VSEL] : 2'b00; // [R14]
      // Open drain: only ever pulls low
      io_oe <= ~power_r | (uart ? drive_low : ~ccr_r[`SCIF_B_MIO]); // [R12] [R15]
    end
  end
  assign io_out = 1'b0;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_removed;
    ce && present_r && !present_nxt;
  endsequence
  sequence s_powered_down;
    !power_r && !present_r ##1 !card_out.vcc_on;
  endsequence

  property p_wt_start;
    ce && sbit && uart && wait_count_enable && !wr_en |=> wt_cnt_r == wt_ld_r;
  endproperty
  a_wt_start: assert property (p_wt_start) else $error("wait counter not reloaded"); // [R1]
  property p_wt_write;
    ce && wr_wt2 && !wait_count_enable |=> wt_cnt_r[23:16] == $past(apb.pwdata[7:0]);
  endproperty
  a_wt_write: assert property (p_wt_write) else $error("wait counter not loaded"); // [R2]
  property p_wt_hold;
    ce && !wait_count_enable && !wr_wt2 |=> $stable(wt_cnt_r);
  endproperty
  a_wt_hold: assert property (p_wt_hold) else $error("wait counter ran while off"); // [R4]
  property p_irq_or;
    ce && ev_m != 8'h00 |=> card_irq;
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("combined irq mismatch"); // [R5]
  property p_rd_clear;
    ce && rd_ipr && ev_m == 8'h00 |=> (ipr_r & $past(prdata[7:0])) == 8'h00;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("pending not cleared"); // [R6]
  property p_ev_kept;
    ce && ev_m != 8'h00 |=> (ipr_r & $past(ev_m)) == $past(ev_m);
  endproperty
  a_ev_kept: assert property (p_ev_kept) else $error("pending event lost"); // [R7]
  property p_present;
    ce && present_nxt != present_r |=> $changed(present_r);
  endproperty
  a_present: assert property (p_present) else $error("presence missed"); // [R9]
  property p_power_card;
    power_r |-> present_r;
  endproperty
  a_power_card: assert property (p_power_card) else $error("power without card"); // [R10]
  property p_removal;
    s_removed |=> s_powered_down;
  endproperty
  a_removal: assert property (p_removal) else $error("removal did not cut power"); // [R11]
  property p_deact;
    ce && !power_r |=> !card_out.clk && !card_out.aux_a && !card_out.aux_b && io_oe;
  endproperty
  a_deact: assert property (p_deact) else $error("pins active without power"); // [R12]
  property p_srst;
    ce && srst && !wr_txb |=> st_r == SCIF_IDLE && !txfull_r;
  endproperty
  a_srst: assert property (p_srst) else $error("engine ran in soft reset"); // [R13]
  property p_vsel;
    ce && power_r |=> card_out.vsel == $past(ctrl_r[`SCIF_F_VSEL]);
  endproperty
  a_vsel: assert property (p_vsel) else $error("voltage select mismatch"); // [R14]
  property p_manual_io;
    ce && power_r && !uart |=> io_oe == !$past(ccr_r[`SCIF_B_MIO]);
  endproperty
  a_manual_io: assert property (p_manual_io) else $error("manual io mismatch"); // [R15]
  property p_tx_fail;
    ce && tx_fail |=> parity_error_flag_r && !$rose(sent_r) && st_r == SCIF_IDLE;
  endproperty
  a_tx_fail: assert property (p_tx_fail) else $error("refusal not flagged"); // [R19]
  property p_no_repeat;
    ce && !auto_repeat_enable && end_rx && err_r |-> !retry ##1 parity_error_flag_r;
  endproperty
  a_no_repeat: assert property (p_no_repeat) else $error("parity flag late"); // [R18]
  property p_tries;
    tries_r <= `SCIF_REPEAT_MAX;
  endproperty
  a_tries: assert property (p_tries) else $error("too many repetitions"); // [R17]
  property p_sent;
    ce && sent_r && !wr_stat |=> sent_r;
  endproperty
  a_sent: assert property (p_sent) else $error("sent flag dropped"); // [R22]
  property p_wtf;
    ce && wt_ev && !sbit && !wr_wt2 |=> wait_overflow_flag;
  endproperty
  a_wtf: assert property (p_wtf) else $error("overflow flag not set"); // [R21]
endmodule
`default_nettype wire

// >>> scif_card_model.sv
// Card model: presence switch and open-drain I/O line with error signalling
`timescale 1ns/100ps
`default_nettype none
module scif_card_model #(
  parameter int E = 40
) (
  input wire logic pclk,
  input wire logic io_oe,
  input wire logic present,
  input wire logic pol,
  input wire logic nack,
  input wire logic card_drive,
  output var scif_pkg::scif_card_in_t card_in,
  output logic io_in,
  output var int starts
);
  import scif_pkg::*;
  logic pull = 1'b0;
  // Pull-up holds the line high whenever nobody pulls it low
  assign io_in = !(io_oe | pull | card_drive);
  assign card_in = '{det: present ^ pol, overload: 1'b0, supply_ok: 1'b1};
  initial
  begin
    starts = 0;
    forever
    begin
      @(negedge io_in);
      starts++;
      repeat (10 * E + 2) @(posedge pclk);
      // Error pulse spans the middle of the first guard bit only
      if (nack)
      begin
        pull <= 1'b1;
        repeat (E - 4) @(posedge pclk);
        pull <= 1'b0;
      end
      repeat (E / 2) @(posedge pclk);
    end
  end
endmodule
`default_nettype wire

// >>> tb_top.sv
// Register-level testbench of the smartcard control block
`timescale 1ns/100ps
`default_nettype none
`include "scif_cfg.svh"
module tb_top;
  import scif_pkg::*;
  localparam int E = 40;
  logic pclk, presetn, present, pol, nack, pready, pslverr, io_in, io_out, io_oe;
  logic card_irq, insert_irq, err, card_drive;
  logic [31:0] prdata, r;
  logic [9:0] got, exp;
  scif_apb_req_t apb;
  scif_card_in_t card_in;
  scif_card_out_t card_out;
  int fails = 0, compares = 0, starts, ins = 0, s0, i, c;
  scif_ctrl #(.ETU_CYCLES(E)) u_scif_ctrl (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .apb(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .card_in(card_in),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .card_out(card_out),
    .card_irq(card_irq), .insert_irq(insert_irq));
  scif_card_model #(.E(E)) u_scif_card_model (.pclk(pclk), .io_oe(io_oe),
    .present(present), .pol(pol), .nack(nack), .card_drive(card_drive),
    .card_in(card_in), .io_in(io_in), .starts(starts));
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk)
    if (insert_irq === 1'b1)
      ins <= ins + 1;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    apb <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge pclk);
    apb.penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a wait for the slave
    while (pready !== 1'b1)
      @(posedge pclk);
    r = prdata;
    err = pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic report_and_stop;
    $display("Compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge pclk);
    fails++;
    report_and_stop;
  end
  initial
  begin
    presetn = 1'b0;
    present = 1'b0;
    pol = 1'b0;
    nack = 1'b0;
    card_drive = 1'b0;
    apb = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(`SCIF_OFS_CTRL);
    chk("ctrl reset", 32'h00, r);
    rd(`SCIF_OFS_STAT);
    chk("status reset", 32'h80, r & 32'hef);
    rd(8'h3c);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, r);
    wr(`SCIF_OFS_CONT, 32'h01);
    rd(`SCIF_OFS_CONT);
    chk("power no card", 32'h0, r & 32'h1);
    wr(`SCIF_OFS_CTRL, 32'h40);
    rd(`SCIF_OFS_STAT);
    chk("present pol1 open", 32'h40, r & 32'h40);
    pol <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(`SCIF_OFS_STAT);
    chk("present pol1 closed", 32'h0, r & 32'h40);
    wr(`SCIF_OFS_CTRL, 32'h00);
    pol <= 1'b0;
    wr(`SCIF_OFS_MISC, 32'h01);
    i = ins;
    present <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(`SCIF_OFS_STAT);
    chk("present insert", 32'h40, r & 32'h40);
    chk("insert pulse", 32'h1, ins - i);
    wr(`SCIF_OFS_CONT, 32'h01);
    for (c = 0; c < 4; c++)
    begin
      wr(`SCIF_OFS_CTRL, c << 4);
      repeat (3) @(posedge pclk);
      chk("vsel", c, {30'h0, card_out.vsel});
    end
    chk("vcc on", 32'h1, {31'h0, card_out.vcc_on});
    chk("manual io low", 32'h1, {31'h0, io_oe});
    // Release the line before UART mode so the engine starts from idle high
    wr(`SCIF_OFS_CONT, 32'h09);
    repeat (3) @(posedge pclk);
    chk("manual io high", 32'h0, {31'h0, io_oe});
    wr(`SCIF_OFS_IEN, 32'h08);
    wr(`SCIF_OFS_CTRL, 32'h08);
    wr(`SCIF_OFS_WT0, 32'h00);
    wr(`SCIF_OFS_WT1, 32'h00);
    wr(`SCIF_OFS_WT2, 32'h00);
    rd(`SCIF_OFS_STAT);
    chk("wait zero load", 32'h08, r & 32'h08);
    rd(`SCIF_OFS_IPEND);
    wr(`SCIF_OFS_WT0, 32'h03);
    wr(`SCIF_OFS_WT2, 32'h00);
    rd(`SCIF_OFS_STAT);
    chk("wait reload", 32'h0, r & 32'h08);
    wr(`SCIF_OFS_CTRL, 32'h00);
    wr(`SCIF_OFS_WT2, 32'h00);
    repeat (8 * E) @(posedge pclk);
    rd(`SCIF_OFS_STAT);
    chk("wait held", 32'h0, r & 32'h08);
    chk("irq idle", 32'h0, {31'h0, card_irq});
    wr(`SCIF_OFS_CTRL, 32'h04);
    repeat (5 * E) @(posedge pclk);
    rd(`SCIF_OFS_STAT);
    chk("wait expired", 32'h08, r & 32'h08);
    chk("irq raised", 32'h1, {31'h0, card_irq});
    rd(`SCIF_OFS_IPEND);
    chk("pending wait", 32'h08, r & 32'h08);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, card_irq});
    for (c = 0; c < 2; c++)
    begin
      wr(`SCIF_OFS_CTRL, 32'h0c | c);
      // Load registers already hold the block timeout before this start bit
      wr(`SCIF_OFS_TXB, 32'h3b);
      rd(`SCIF_OFS_STAT);
      chk("wait start reload", 32'h0, r & 32'h08);
      while (io_in !== 1'b0)
        @(posedge pclk);
      repeat (E / 2) @(posedge pclk);
      for (i = 0; i < 10; i++)
      begin
        got[i] = io_in;
        repeat (E) @(posedge pclk);
      end
      exp[0] = 1'b0;
      for (i = 0; i < 8; i++)
        exp[i + 1] = c ? !(8'h3b >> (7 - i) & 1) : (8'h3b >> i & 1);
      exp[9] = c ? !(^8'h3b) : ^8'h3b;
      chk("tx frame", exp, got);
      repeat (3 * E) @(posedge pclk);
      rd(`SCIF_OFS_STAT);
      chk("sent set", 32'h0c, r & 32'h0c);
      // Character timeout goes in only after the sent event
      wr(`SCIF_OFS_WT0, 32'h03);
      rd(`SCIF_OFS_STAT);
      chk("sent held", 32'h04, r & 32'h04);
      wr(`SCIF_OFS_STAT, 32'h00);
      rd(`SCIF_OFS_STAT);
      chk("sent cleared", 32'h0, r & 32'h04);
    end
    for (c = 0; c < 2; c++)
    begin
      wr(`SCIF_OFS_CTRL, 32'h08 | c << 1);
      nack <= 1'b1;
      repeat (13 * E) @(posedge pclk);
      s0 = starts;
      wr(`SCIF_OFS_TXB, 32'h55);
      r = 32'h0;
      while (r[0] !== 1'b1 && r[2] !== 1'b1)
        rd(`SCIF_OFS_STAT);
      repeat (13 * E) @(posedge pclk);
      chk("tx attempts", c ? 5 : 1, starts - s0);
      rd(`SCIF_OFS_STAT);
      // Without repetition the card's error signal is ignored and the character counts as sent
      chk("refused flags", c ? 32'h01 : 32'h04, r & 32'h05);
      wr(`SCIF_OFS_STAT, 32'h00);
      nack <= 1'b0;
    end
    wr(`SCIF_OFS_CTRL, 32'h08);
    for (c = 0; c < 2; c++)
    begin
      exp = {^8'ha5 ^ c[0], 8'ha5, 1'b0};
      for (i = 0; i < 10; i++)
      begin
        card_drive <= !exp[i];
        repeat (E) @(posedge pclk);
      end
      card_drive <= 1'b0;
      repeat (3 * E) @(posedge pclk);
      rd(`SCIF_OFS_STAT);
      chk("rx flags", 32'h02 | c, r & 32'h03);
      rd(`SCIF_OFS_RXB);
      chk("rx byte", 32'ha5, r);
      wr(`SCIF_OFS_STAT, 32'h00);
    end
    s0 = starts;
    wr(`SCIF_OFS_CTRL, 32'h88);
    wr(`SCIF_OFS_TXB, 32'h3b);
    repeat (2 * E) @(posedge pclk);
    rd(`SCIF_OFS_STAT);
    chk("reset tx empty", 32'h80, r & 32'h80);
    chk("reset no tx", 32'h0, starts - s0);
    wr(`SCIF_OFS_CTRL, 32'h08);
    wr(`SCIF_OFS_TXB, 32'h3b);
    repeat (13 * E) @(posedge pclk);
    chk("reset released", 32'h1, starts - s0);
    i = ins;
    present <= 1'b0;
    repeat (4) @(posedge pclk);
    rd(`SCIF_OFS_STAT);
    chk("present removed", 32'h0, r & 32'h40);
    chk("removal pulse", 32'h1, ins - i);
    rd(`SCIF_OFS_CONT);
    chk("power cleared", 32'h0, r & 32'h1);
    chk("pins off", 32'h0, {25'h0, card_out});
    chk("io off", 32'h1, {31'h0, io_oe});
    report_and_stop;
  end
endmodule
`default_nettype wire
